/* verilog/eits_top.v */
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "eits_consts.vh"

// How it works
// RULE_01 - Modes: 00 fall, 01 rise, 10 low, 11 both
// RULE_02 - LED fields bits 21-6, NMI bits 1-0
// RULE_03 - Bits 23-22 always read 01b
// RULE_04 - Bits 31-24 and 5-2 read zero
// RULE_05 - Held low pin repeats requests as pulses
// RULE_06 - Sampling clock never stops in standby
// RULE_07 - NMI low level gives exactly one request
// RULE_08 - Protected writes need unlock first
// RULE_09 - Reads need no unlock
// RULE_10 - Software uses 32-bit accesses only
// RULE_11 - Four 7-bit source selectors, upper bits zero
// RULE_12 - Codes 00H-13H timers and serial units
// RULE_13 - Codes 1AH-26H DMA, timer array, PHY
// RULE_14 - Codes 33H-4FH pins, some shared with timers
// RULE_15 - LED and network controller codes
// RULE_16 - Software avoids prohibited selector codes
// RULE_17 - Pin used as trigger uses edge mode
// RULE_18 - Each port group updates 8 bits together
// RULE_19 - Pins synchronised, one pulse per edge
module eits_top #(
   parameter NUM_EXT = 29,
   parameter NUM_LED = 8,
   parameter NUM_PORT = 4,
   parameter GROUP_W = 8
) (
   input wire CORE_CLK,
   input wire RST_B,
   input wire [11:0] ADDR,
   input wire [31:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [31:0] RDATA,
   input wire PROT_UNLOCK,
   input wire NMI_PIN_B,
   input wire [NUM_EXT-1:0] EXT_IRQ_PINS,
   input wire [NUM_LED-1:0] PHY_LED_PINS,
   input wire [3:0] TIMER_OUT,
   input wire [3:0] TIMER_J2_IRQ,
   input wire [11:0] SERIAL_IRQ,
   input wire [3:0] GDMA_DONE,
   input wire RTP_DMA_DONE,
   input wire [15:0] TIMER_ARRAY_D_IRQ,
   input wire IBUF_DMA_DONE,
   input wire [1:0] PHY_PORT_IRQ,
   input wire NET_NMI_IRQ,
   input wire NET_WDT_IRQ,
   input wire NET_GEN_IRQ,
   input wire [10:0] TIMER_SHARE_SEL,
   input wire [NUM_PORT*GROUP_W-1:0] RP_NEXT,
   output reg NMI_REQ,
   output reg [NUM_LED-1:0] LED_REQ,
   output reg [NUM_EXT-1:0] EXT_REQ,
   output reg [NUM_PORT-1:0] SYNC_TRIG,
   output reg [NUM_PORT*GROUP_W-1:0] RP_OUT,
   output reg IRQ
);

   localparam NPIN = 1 + NUM_LED + NUM_EXT;
   // LED0 and LED1 lines of each PHY inside the request vector
   localparam LED0_P0 = 1;
   localparam LED1_P0 = 2;
   localparam LED0_P1 = 1 + NUM_LED / 2;
   localparam LED1_P1 = 2 + NUM_LED / 2;

   // Index 0 is the NMI pin, then LEDs, then general pins
   reg [NPIN-1:0] sync1;
   reg [NPIN-1:0] sync2;
   reg [NPIN-1:0] sync3;
   reg [NPIN-1:0] filt;
   reg [NPIN-1:0] filt_d;
   reg [NPIN-1:0] tog;
   reg [NPIN-1:0] next_tog;
   reg [NPIN-1:0] next_req;

   reg [31:0] trig_mode;
   reg [`EITS_PINMODE_W-1:0] pin_mode;
   reg [`EITS_SRC_W*NUM_PORT-1:0] src_sel;
   reg [`EITS_ST_W-1:0] status;
   reg [`EITS_ST_W-1:0] mask;
   reg [`EITS_ST_W-1:0] next_status;
   reg [`EITS_ST_W-1:0] next_mask;
   reg [127:0] sources;
   reg [NUM_PORT-1:0] next_trig;
   reg [31:0] next_rdata;
   reg [1:0] mode_i;
   reg prot_hit;
   wire [NPIN-1:0] pin_raw;
   integer i;
   integer j;
   integer p;

   assign pin_raw = {EXT_IRQ_PINS, PHY_LED_PINS, NMI_PIN_B};

   // One request per qualifying event on the filtered level
   function detect;
      input [1:0] mode;
      input cur;
      input prev;
      input tg;
      input one_shot;
      begin
         case (mode)
            `EITS_TRIG_FALL: detect = prev & ~cur; // see RULE_01
            `EITS_TRIG_RISE: detect = ~prev & cur; // see RULE_01
            `EITS_TRIG_LOW: begin
               if (one_shot) begin
                  detect = prev & ~cur; // see RULE_07
               end else begin
                  detect = ~cur & ~tg; // see RULE_05
               end
            end
            default: detect = prev ^ cur; // see RULE_01
         endcase
      end
   endfunction

   // Decode that selects one of the six write-protected registers
   function is_protected;
      input [11:0] a;
      begin
         is_protected = (a == `EITS_ADDR_MODE) ||
            (a == `EITS_ADDR_PINMODE) ||
            (a == `EITS_ADDR_SRC0) || (a == `EITS_ADDR_SRC1) ||
            (a == `EITS_ADDR_SRC2) || (a == `EITS_ADDR_SRC3);
      end
   endfunction

   // CORE_CLK is never gated here, so detection keeps going in standby
   always @(posedge CORE_CLK) begin // see RULE_06
      if (!RST_B) begin
         sync1 <= {NPIN{1'b1}};
         sync2 <= {NPIN{1'b1}};
         sync3 <= {NPIN{1'b1}};
      end else begin
         sync1 <= pin_raw; // see RULE_19
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // Idle high after reset so no false edge follows its release
   always @(posedge CORE_CLK) begin
      if (!RST_B) begin
         filt <= {NPIN{1'b1}};
         filt_d <= {NPIN{1'b1}};
         tog <= {NPIN{1'b0}};
      end else begin
         // A change counts only once the last two stages agree
         filt <= (sync2 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
         filt_d <= filt;
         tog <= next_tog;
      end
   end

   always @* begin
      next_req = {NPIN{1'b0}};
      next_tog = {NPIN{1'b0}};
      mode_i = `EITS_TRIG_FALL;
      for (i = 0; i < NPIN; i = i + 1) begin
         if (i == 0) begin
            mode_i = trig_mode[`EITS_MODE_NMI_LSB +: 2]; // see RULE_02
         end else if (i <= NUM_LED) begin
            mode_i = trig_mode[`EITS_MODE_LED_LSB + 2*(i-1) +: 2];
         end else begin
            mode_i = pin_mode;
         end
         next_req[i] = detect(mode_i, filt[i], filt_d[i], tog[i],
            i == 0); // see RULE_19
         // Held low acts like a square wave at half the clock rate on the pin
         if (mode_i == `EITS_TRIG_LOW && !filt[i]) begin
            next_tog[i] = ~tog[i]; // see RULE_05
         end
      end
   end

   // Selectable request sources indexed by selector code
   always @* begin
      sources = 128'h0;
      sources[`EITS_CODE_TOUT +: 4] = TIMER_OUT; // see RULE_12
      sources[`EITS_CODE_TJ2 +: 4] = TIMER_J2_IRQ; // see RULE_12
      sources[`EITS_CODE_SER +: 12] = SERIAL_IRQ; // see RULE_12
      sources[`EITS_CODE_GDMA +: 4] = GDMA_DONE; // see RULE_13
      sources[`EITS_CODE_RTDMA] = RTP_DMA_DONE; // see RULE_13
      sources[`EITS_CODE_TIMER_ARRAY_D +: 5] = TIMER_ARRAY_D_IRQ[4:0]; // see RULE_13
      sources[`EITS_CODE_IBDMA] = IBUF_DMA_DONE; // see RULE_13
      sources[`EITS_CODE_PHY +: 2] = PHY_PORT_IRQ; // see RULE_13
      sources[`EITS_CODE_EXT +: NUM_EXT] =
         next_req[1+NUM_LED +: NUM_EXT]; // see RULE_14
      for (j = 0; j < 11; j = j + 1) begin
         if (TIMER_SHARE_SEL[j]) begin
            sources[`EITS_CODE_SHARED + j] = TIMER_ARRAY_D_IRQ[5+j]; // see RULE_14
         end
      end
      // Pins feed the ports from the same pulse that drives the requests
      sources[`EITS_CODE_LED0P0] = next_req[LED0_P0]; // see RULE_15
      sources[`EITS_CODE_LED0P1] = next_req[LED0_P1]; // see RULE_15
      sources[`EITS_CODE_LED1P0] = next_req[LED1_P0]; // see RULE_15
      sources[`EITS_CODE_LED1P1] = next_req[LED1_P1]; // see RULE_15
      sources[`EITS_CODE_NETNMI] = NET_NMI_IRQ; // see RULE_15
      sources[`EITS_CODE_NETWDT] = NET_WDT_IRQ; // see RULE_15
      sources[`EITS_CODE_NETIRQ] = NET_GEN_IRQ; // see RULE_15
      // Prohibited codes stay zero and never fire
      for (j = 0; j < NUM_PORT; j = j + 1) begin
         next_trig[j] = sources[src_sel[`EITS_SRC_W*j +: `EITS_SRC_W]];
      end
   end

   // A refused write leaves a sticky mark for software to find
   always @* begin
      prot_hit = WR && is_protected(ADDR);
      next_status = status;
      if (WR && ADDR == `EITS_ADDR_STATUS) begin
         next_status = status & ~WDATA[`EITS_ST_W-1:0];
      end
      // Set wins over a write-one-to-clear in the same cycle
      next_status[`EITS_ST_TRIG_LSB +: 4] =
         next_status[`EITS_ST_TRIG_LSB +: 4] | next_trig[3:0];
      if (prot_hit && !PROT_UNLOCK) begin
         next_status[`EITS_ST_REFUSED] = 1'b1;
      end
   end

   // Reads are never protected
   always @* begin // see RULE_09
      // Unmapped addresses read as zero
      next_rdata = 32'h0;
      if (ADDR == `EITS_ADDR_MODE) begin
         next_rdata = trig_mode; // see RULE_03
      end else if (ADDR == `EITS_ADDR_PINMODE) begin
         next_rdata = {30'h0, pin_mode};
      end else if (ADDR == `EITS_ADDR_STATUS) begin
         next_rdata = {27'h0, status};
      end else if (ADDR == `EITS_ADDR_MASK) begin
         next_rdata = {27'h0, mask};
      end else if (ADDR == `EITS_ADDR_SRC0) begin
         next_rdata = {25'h0, src_sel[0 +: 7]}; // see RULE_11
      end else if (ADDR == `EITS_ADDR_SRC1) begin
         next_rdata = {25'h0, src_sel[7 +: 7]}; // see RULE_11
      end else if (ADDR == `EITS_ADDR_SRC2) begin
         next_rdata = {25'h0, src_sel[14 +: 7]}; // see RULE_11
      end else if (ADDR == `EITS_ADDR_SRC3) begin
         next_rdata = {25'h0, src_sel[21 +: 7]}; // see RULE_11
      end
   end

   // Only an unlocked write reaches the protected registers
   always @(posedge CORE_CLK) begin
      if (!RST_B) begin
         trig_mode <= `EITS_MODE_RST;
         pin_mode <= `EITS_PINMODE_RST;
      end else if (prot_hit && PROT_UNLOCK) begin // see RULE_08
         if (ADDR == `EITS_ADDR_MODE) begin
            // Reserved bits keep their fixed read values
            trig_mode <= (WDATA & `EITS_MODE_WMASK) |
               `EITS_MODE_FIXED; // see RULE_04
         end else if (ADDR == `EITS_ADDR_PINMODE) begin
            pin_mode <= WDATA[`EITS_PINMODE_W-1:0];
         end
      end
   end

   always @(posedge CORE_CLK) begin
      if (!RST_B) begin
         src_sel <= {NUM_PORT{`EITS_SRC_RST}};
      end else if (prot_hit && PROT_UNLOCK) begin // see RULE_08
         if (ADDR == `EITS_ADDR_SRC0) begin
            src_sel[0 +: 7] <= WDATA[6:0];
         end else if (ADDR == `EITS_ADDR_SRC1) begin
            src_sel[7 +: 7] <= WDATA[6:0];
         end else if (ADDR == `EITS_ADDR_SRC2) begin
            src_sel[14 +: 7] <= WDATA[6:0];
         end else if (ADDR == `EITS_ADDR_SRC3) begin
            src_sel[21 +: 7] <= WDATA[6:0];
         end
      end
   end

   // Mask is not protected; its new value already counts for IRQ
   always @* begin
      next_mask = mask;
      if (WR && ADDR == `EITS_ADDR_MASK) begin
         next_mask = WDATA[`EITS_ST_W-1:0];
      end
   end

   // Read data stand in the cycle after each RD cycle, zero otherwise
   always @(posedge CORE_CLK) begin
      if (!RST_B) begin
         RDATA <= 32'h0;
      end else begin
         RDATA <= RD ? next_rdata : 32'h0;
      end
   end

   // IRQ is built from next values so it never lags a mask write
   always @(posedge CORE_CLK) begin
      if (!RST_B) begin
         status <= `EITS_ST_RST;
         mask <= `EITS_ST_RST;
         IRQ <= 1'b0;
      end else begin
         status <= next_status;
         mask <= next_mask;
         IRQ <= |(next_status & next_mask);
      end
   end

   // One registered pulse per detected event on each pin
   always @(posedge CORE_CLK) begin
      if (!RST_B) begin
         NMI_REQ <= 1'b0;
         LED_REQ <= {NUM_LED{1'b0}};
         EXT_REQ <= {NUM_EXT{1'b0}};
      end else begin
         NMI_REQ <= next_req[0];
         LED_REQ <= next_req[1 +: NUM_LED];
         EXT_REQ <= next_req[1+NUM_LED +: NUM_EXT];
      end
   end

   // A whole group loads at once, never bit by bit
   always @(posedge CORE_CLK) begin
      if (!RST_B) begin
         SYNC_TRIG <= {NUM_PORT{1'b0}};
         RP_OUT <= {NUM_PORT*GROUP_W{1'b0}};
      end else begin
         SYNC_TRIG <= next_trig;
         for (p = 0; p < NUM_PORT; p = p + 1) begin
            if (next_trig[p]) begin
               RP_OUT[GROUP_W*p +: GROUP_W] <=
                  RP_NEXT[GROUP_W*p +: GROUP_W]; // see RULE_18
            end
         end
      end
   end

endmodule
`default_nettype wire

/* pkg/eits_consts.vh */
`ifndef EITS_CONSTS_VH
`define EITS_CONSTS_VH

// Register byte addresses
`define EITS_ADDR_MODE 12'h710
`define EITS_ADDR_PINMODE 12'h714
`define EITS_ADDR_STATUS 12'h720
`define EITS_ADDR_MASK 12'h724
`define EITS_ADDR_SRC0 12'hA30
`define EITS_ADDR_SRC1 12'hA34
`define EITS_ADDR_SRC2 12'hA38
`define EITS_ADDR_SRC3 12'hA3C

// Trigger-mode register layout and reset value
`define EITS_MODE_RST 32'h00400002
`define EITS_MODE_WMASK 32'h003FFFC3
`define EITS_MODE_FIXED 32'h00400000
`define EITS_MODE_NMI_LSB 0
`define EITS_MODE_LED_LSB 6
`define EITS_PINMODE_RST 2'h0
`define EITS_PINMODE_W 2

// Trigger modes
`define EITS_TRIG_FALL 2'h0
`define EITS_TRIG_RISE 2'h1
`define EITS_TRIG_LOW 2'h2
`define EITS_TRIG_BOTH 2'h3

// Trigger-source selector
`define EITS_SRC_W 7
`define EITS_SRC_RST 7'h00
`define EITS_CODE_TOUT 0
`define EITS_CODE_TJ2 4
`define EITS_CODE_SER 8
`define EITS_CODE_GDMA 26
`define EITS_CODE_RTDMA 30
`define EITS_CODE_TIMER_ARRAY_D 31
`define EITS_CODE_IBDMA 36
`define EITS_CODE_PHY 37
`define EITS_CODE_EXT 51
`define EITS_CODE_SHARED 62
`define EITS_CODE_LED0P0 99
`define EITS_CODE_LED0P1 100
`define EITS_CODE_NETNMI 111
`define EITS_CODE_NETWDT 112
`define EITS_CODE_NETIRQ 113
`define EITS_CODE_LED1P0 125
`define EITS_CODE_LED1P1 126

// Status register bits
`define EITS_ST_TRIG_LSB 0
`define EITS_ST_REFUSED 4
`define EITS_ST_W 5
`define EITS_ST_RST 5'h00

`endif

/* bench/eits_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
`include "eits_consts.vh"
module eits_monitor (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic [11:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic PROT_UNLOCK,
   input wire logic NMI_PIN_B,
   input wire logic [3:0] GDMA_DONE,
   input wire logic [31:0] RP_NEXT,
   input wire logic NMI_REQ,
   input wire logic [3:0] SYNC_TRIG,
   input wire logic [31:0] RP_OUT,
   input wire logic IRQ
);
   logic [31:0] mode;
   logic [6:0] sel;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);
   // Shadows take only unlocked writes, so a leaked write shows on read
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         mode <= `EITS_MODE_RST;
         sel <= `EITS_SRC_RST;
      end else if (WR && PROT_UNLOCK && ADDR == `EITS_ADDR_MODE) begin
         mode <= (WDATA & `EITS_MODE_WMASK) | `EITS_MODE_FIXED;
      end else if (WR && PROT_UNLOCK && ADDR == `EITS_ADDR_SRC0) begin
         sel <= WDATA[6:0];
      end
   end
   a_rdata_idle: assert property (
      RDATA != 32'h0 |-> $past(RD)) else $error("stray read data");
   a_mode_read: assert property (
      RD && ADDR == `EITS_ADDR_MODE |=> RDATA == mode)
      else $error("mode readback");
   a_sel_read: assert property (
      RD && ADDR == `EITS_ADDR_SRC0 |=> RDATA == {25'h0, sel})
      else $error("selector readback");
   a_nmi_single: assert property (
      NMI_REQ |=> !NMI_REQ) else $error("long request");
   a_nmi_sync: assert property (
      $rose(NMI_REQ) |-> $past(NMI_PIN_B, 3) != $past(NMI_PIN_B, 8))
      else $error("request without pin change");
   a_rp_load: assert property (
      SYNC_TRIG[0] |-> RP_OUT[7:0] == $past(RP_NEXT[7:0]))
      else $error("group not loaded");
   a_rp_hold: assert property (
      !SYNC_TRIG[3] |-> $stable(RP_OUT[31:24]))
      else $error("group moved");
   a_dma_trig: assert property (
      sel == 7'h1A && $stable(sel) |-> SYNC_TRIG[0] == $past(GDMA_DONE[0]))
      else $error("dma trigger");
endmodule
bind eits_top eits_monitor mon (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
   .PROT_UNLOCK(PROT_UNLOCK), .NMI_PIN_B(NMI_PIN_B),
   .GDMA_DONE(GDMA_DONE), .RP_NEXT(RP_NEXT), .NMI_REQ(NMI_REQ),
   .SYNC_TRIG(SYNC_TRIG), .RP_OUT(RP_OUT), .IRQ(IRQ));
`default_nettype wire

/* bench/eits_pins.sv */
`timescale 1ns/10ps
`default_nettype none
// Far side pins; levels held, never released
module eits_pins (
   input wire logic clk,
   output logic nmi_b,
   output logic [28:0] ext,
   output logic [7:0] led
);
   initial begin
      nmi_b = 1'h1;
      ext = '1;
      led = '1;
   end
   // 0-28 general pins, 29-36 LED lines, 37 the NMI pin
   task automatic put(input integer k, input logic v);
      @(posedge clk);
      if (k == 37) nmi_b <= v;
      else if (k > 28) led[k - 29] <= v;
      else ext[k] <= v;
   endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "eits_consts.vh"
module tb;
   logic clk = 1'h0, rst_b = 1'h0, wr = 1'h0, rd = 1'h0, unl = 1'h0;
   logic [11:0] addr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata, rpn = 32'h0, rpo;
   logic [46:0] src = 47'h0;
   logic [10:0] share = 11'h0;
   logic nmi_b, nmi_req, irq;
   logic [28:0] ext, ext_req;
   logic [7:0] led, led_req;
   logic [3:0] trig;
   wire [37:0] reqv = {nmi_req, led_req, ext_req};
   integer seed = 32'h7e19d139, num_errors = 0, comparisons = 0;
   integer i, k, c, n, t;
   integer pc [7] = '{8'h33, 8'h4F, 8'h63, 8'h64, 8'h7D, 8'h7E, 8'h3E};
   integer pk [7] = '{0, 28, 29, 33, 30, 34, 11};
   eits_top dut (.CORE_CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .PROT_UNLOCK(unl), .NMI_PIN_B(nmi_b),
      .EXT_IRQ_PINS(ext), .PHY_LED_PINS(led), .TIMER_OUT(src[3:0]),
      .TIMER_J2_IRQ(src[7:4]), .SERIAL_IRQ(src[19:8]),
      .GDMA_DONE(src[23:20]), .RTP_DMA_DONE(src[24]),
      .TIMER_ARRAY_D_IRQ(src[40:25]), .IBUF_DMA_DONE(src[41]),
      .PHY_PORT_IRQ(src[43:42]), .NET_NMI_IRQ(src[44]),
      .NET_WDT_IRQ(src[45]), .NET_GEN_IRQ(src[46]),
      .TIMER_SHARE_SEL(share), .RP_NEXT(rpn), .NMI_REQ(nmi_req),
      .LED_REQ(led_req), .EXT_REQ(ext_req), .SYNC_TRIG(trig),
      .RP_OUT(rpo), .IRQ(irq));
   eits_pins pins (.clk(clk), .nmi_b(nmi_b), .ext(ext), .led(led));
   initial forever #2.5 clk = ~clk;
   // Bit of src that a selector code should follow; -1 for pins and gaps
   function automatic integer sbit(input integer c);
      if (c <= 8'h13) return c;
      if (c >= 8'h1A && c <= 8'h23) return c - 6;
      if (c == 8'h24) return 41;
      if (c == 8'h25 || c == 8'h26) return c + 5;
      if (c >= 8'h3E && c <= 8'h48) return c - 32;
      if (c >= 8'h6F && c <= 8'h71) return c - 67;
      return -1;
   endfunction
   task chk(input string s, input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task wreg(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task rreg(input logic [11:0] a, input logic [31:0] e, input string s);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1 chk(s, rdata, e);
   endtask
   task fire(input integer b, input integer p);
      logic [31:0] r;
      @(posedge clk);
      src <= 47'h1 << b;
      rpn <= $random(seed);
      @(posedge clk);
      r = rpn;
      src <= 47'h0;
      #1 chk("trigger", trig[p], 1'h1);
      chk("group", rpo[p*8+:8], r[p*8+:8]);
   endtask
   task pin(input integer k, input logic v, input integer m,
            output integer n, output integer t);
      n = 0;
      t = 0;
      pins.put(k, v);
      repeat (m) begin
         @(posedge clk);
         #1 n += reqv[k];
         t += trig[1];
      end
   endtask
   task tally_and_finish;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      tally_and_finish;
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1'h1;
      rreg(`EITS_ADDR_MODE, `EITS_MODE_RST, "mode");
      for (i = 0; i < 4; i++)
         rreg(12'hA30 + 12'(i * 4), 32'h0, "sel");
      rreg(12'h7F0, 32'h0, "unmapped");
      c = `EITS_MODE_FIXED | ($random(seed) & `EITS_MODE_WMASK);
      wreg(`EITS_ADDR_MODE, c);
      rreg(`EITS_ADDR_MODE, `EITS_MODE_RST, "locked");
      rreg(`EITS_ADDR_STATUS, 32'h10, "refused");
      @(posedge clk);
      unl <= 1'h1;
      wreg(`EITS_ADDR_MODE, c);
      rreg(`EITS_ADDR_MODE, c, "mode");
      @(posedge clk);
      share <= 11'h7FF;
      for (c = 0; c < 128; c++) begin
         n = sbit(c);
         if (n >= 0) begin
            k = $random(seed) & 3;
            wreg(12'hA30 + 12'(k * 4), c);
            rreg(12'hA30 + 12'(k * 4), c, "sel");
            fire(n, k);
         end
      end
      wreg(`EITS_ADDR_STATUS, 32'h1F);
      wreg(`EITS_ADDR_MASK, 32'h01);
      wreg(`EITS_ADDR_SRC0, 32'h1A);
      #1 chk("irq", irq, 1'h0);
      fire(20, 0);
      chk("irq", irq, 1'h1);
      wreg(`EITS_ADDR_MASK, 32'h00);
      #1 chk("irq", irq, 1'h0);
      rreg(`EITS_ADDR_STATUS, 32'h01, "status");
      wreg(`EITS_ADDR_STATUS, 32'h01);
      wreg(`EITS_ADDR_MASK, 32'h01);
      rreg(`EITS_ADDR_MASK, 32'h01, "mask");
      rreg(`EITS_ADDR_STATUS, 32'h00, "status");
      chk("irq", irq, 1'h0);
      @(posedge clk);
      share <= 11'h0;
      wreg(`EITS_ADDR_MODE, `EITS_MODE_RST);
      for (i = 0; i < 7; i++) begin
         wreg(`EITS_ADDR_SRC1, pc[i]);
         pin(pk[i], 1'h0, 12, n, t);
         chk("pin req", n, 1);
         chk("pin trig", t, 1);
         pin(pk[i], 1'h1, 12, n, t);
      end
      wreg(`EITS_ADDR_SRC1, 32'h0);
      for (i = 0; i < 4; i++) begin
         wreg(`EITS_ADDR_MODE, `EITS_MODE_FIXED | (i << 16));
         pin(34, 1'h0, 20, n, t);
         if (i == 2) chk("low", n >= 5, 1'h1);
         else chk("fall", n, i != 1);
         pin(34, 1'h1, 20, n, t);
         if (i != 2) chk("rise", n, i[0]);
      end
      wreg(`EITS_ADDR_PINMODE, 32'h2);
      rreg(`EITS_ADDR_PINMODE, 32'h2, "pinmode");
      pin(3, 1'h0, 20, n, t);
      chk("pin low", n >= 5, 1'h1);
      wreg(`EITS_ADDR_PINMODE, 32'h0);
      pin(3, 1'h1, 12, n, t);
      wreg(`EITS_ADDR_MODE, `EITS_MODE_RST);
      pin(37, 1'h0, 30, n, t);
      chk("nmi", n, 1);
      pin(37, 1'h1, 12, n, t);
      chk("nmi", n, 0);
      tally_and_finish;
   end
endmodule
`default_nettype wire
